// >>> ext_irq_cfg.svh
// Purpose: named constants for the external pin interrupt unit
// Assumes: included by the package and by every design file
// Notes: the guard makes repeated inclusion harmless
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

// register port shape
`define ADDR_W 3
`define DATA_W 8
`define NUM_CH 2

// register offsets on the plain register port
`define OFF_SENSE 3'h0
`define OFF_ENABLE 3'h1
`define OFF_FLAGS 3'h2
`define OFF_EVT_STAT 3'h3
`define OFF_EVT_MASK 3'h4

// reset value shared by all software registers
`define RST_BYTE 8'h00

// field positions
`define SENSE_W 2
`define ENA_CH0_BIT 6
`define FLAG_CH0_BIT 6
`define ENA_RW_MASK 8'hc3

// event status layout: bit per channel, then wake
`define EVT_W 3
`define EVT_WAKE 2

// input synchroniser: pin 0, pin 1, watchdog oscillator
`define SYNC_W 3
`define SYNC_WDT 2
`define SYNC_RST 3'h3

`endif

// >>> ext_irq_pkg.sv
// Purpose: types of the external pin interrupt unit
// Assumes: ext_irq_cfg.svh provides the widths
// Notes: every design module keeps its whole state in one struct from here
`include "ext_irq_cfg.svh"

package ext_irq_pkg;

    // request condition per channel
    typedef enum logic [1:0] {
        SENSE_LOW = 2'h0,
        SENSE_ANY = 2'h1,
        SENSE_FALL = 2'h2,
        SENSE_RISE = 2'h3
    } sense_t;

    // low-level wake qualifier
    typedef enum logic [2:0] {
        WAKE_IDLE = 3'h1,
        WAKE_ARMED = 3'h2,
        WAKE_HELD = 3'h4
    } wake_fsm_t;

    typedef struct packed {
        logic [`SYNC_W-1:0] s1;
        logic [`SYNC_W-1:0] s2;
        logic [`SYNC_W-1:0] s3;
        logic [`SYNC_W-1:0] filt;
    } sync_state_t;

    typedef struct packed {
        wake_fsm_t fsm;
        logic wake;
    } wake_state_t;

    typedef struct packed {
        logic [`DATA_W-1:0] sense;
        logic [`DATA_W-1:0] enable;
        logic [`NUM_CH-1:0] flag;
        logic [`EVT_W-1:0] evt_stat;
        logic [`EVT_W-1:0] evt_mask;
        logic [`NUM_CH-1:0] pin_prev;
        logic wdt_prev;
        logic [`DATA_W-1:0] rdata;
        logic [`NUM_CH-1:0] req;
        logic wake;
        logic irq;
    } irq_state_t;

endpackage : ext_irq_pkg

// >>> pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: raw inputs are asynchronous to ref_clk
// Notes: a new level is taken once stages two and three agree
`timescale 1ns/1ns
`include "ext_irq_cfg.svh"

module pin_sync import ext_irq_pkg::*; (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // asynchronous inputs
    input wire logic [`SYNC_W-1:0] raw,
    // filtered levels
    output logic [`SYNC_W-1:0] level
);

    sync_state_t q;
    sync_state_t d;

    // stage one is seen only by stage two
    always_comb begin
        d = q;
        d.s1 = raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
        d.filt = (q.s2 & ~(q.s2 ^ q.s3)) | (q.filt & (q.s2 ^ q.s3));
    end

    // pins rest high so reset never looks like a low level
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{s1: `SYNC_RST, s2: `SYNC_RST, s3: `SYNC_RST,
                   filt: `SYNC_RST};
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign level = q.filt;

endmodule : pin_sync

// >>> level_wake.sv
// Purpose: qualify a low level for wake-up from power-down
// Assumes: sample_stb marks one watchdog oscillator edge
// Notes: two consecutive low samples wake; start-up end rearms
`timescale 1ns/1ns
`include "ext_irq_cfg.svh"

module level_wake import ext_irq_pkg::*; (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // qualifying inputs
    input wire logic sample_stb,
    input wire logic [`NUM_CH-1:0] low_req,
    input wire logic power_down,
    input wire logic startup_done,
    // one-cycle wake pulse
    output logic wake
);

    wake_state_t q;
    wake_state_t d;

    // a single noisy sample is not enough to wake
    always_comb begin
        d = q;
        d.wake = 1'b0;
        case (q.fsm)
            WAKE_IDLE: begin
                if (power_down && sample_stb && (|low_req)) begin
                    d.fsm = WAKE_ARMED;
                end
            end
            WAKE_ARMED: begin
                if (!power_down) begin
                    d.fsm = WAKE_IDLE;
                end else if (sample_stb) begin
                    if (|low_req) begin
                        d.fsm = WAKE_HELD;
                        d.wake = 1'b1;
                    end else begin
                        d.fsm = WAKE_IDLE;
                    end
                end
            end
            WAKE_HELD: begin
                // woken even if the level is gone before start-up ends
                if (startup_done) begin
                    d.fsm = WAKE_IDLE;
                end
            end
            default: begin
                d.fsm = WAKE_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{fsm: WAKE_IDLE, wake: 1'b0};
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign wake = q.wake;

endmodule : level_wake

// >>> external_pin_interrupt_unit.sv
// Purpose: two-channel external pin interrupt unit
// Assumes: io_clk_run, power_down, startup_done, global_irq_en and
//          the acknowledge come from logic on ref_clk
// Notes: pins and the watchdog oscillator are synchronised here
`timescale 1ns/1ns
`include "ext_irq_cfg.svh"

module external_pin_interrupt_unit import ext_irq_pkg::*; (
    // clock, reset, enable
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic clk_en,
    // register port
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [`DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DATA_W-1:0] reg_rdata,
    // interrupt pins, observed whatever drives them
    input wire logic ext_irq_pin_0,
    input wire logic ext_irq_pin_1,
    // watchdog oscillator clock, sampled as a plain input
    input wire logic wdt_osc,
    // processor side
    input wire logic global_irq_en,
    input wire logic irq_ack,
    input wire logic irq_ack_ch,
    input wire logic io_clk_run,
    input wire logic power_down,
    input wire logic startup_done,
    output logic [`NUM_CH-1:0] irq_req,
    output logic wake_req,
    // summary interrupt
    output logic event_irq
);

    irq_state_t q;
    irq_state_t d;

    logic [`SYNC_W-1:0] sync_lvl;
    logic [`NUM_CH-1:0] pin_lvl;
    logic wdt_lvl;
    logic wdt_stb;
    logic [`NUM_CH-1:0] wake_low;
    logic wake_pulse;

    // channel sense field out of the control byte
    function automatic sense_t sense_of(
        input logic [`DATA_W-1:0] ctl,
        input int ch
    );
        logic [`SENSE_W-1:0] f;
        f = ctl[ch*`SENSE_W +: `SENSE_W];
        return sense_t'(f);
    endfunction : sense_of

    // does this sample pair meet the edge condition of the mode
    function automatic logic edge_hit(
        input sense_t mode,
        input logic cur,
        input logic prev
    );
        logic hit;
        case (mode)
            SENSE_ANY: hit = cur ^ prev;
            SENSE_FALL: hit = prev & ~cur;
            SENSE_RISE: hit = cur & ~prev;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : edge_hit

    // pins are sampled before any edge logic sees them
    pin_sync u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .raw({wdt_osc, ext_irq_pin_1, ext_irq_pin_0}),
        .level(sync_lvl)
    );

    assign pin_lvl = sync_lvl[`NUM_CH-1:0];
    assign wdt_lvl = sync_lvl[`SYNC_WDT];
    assign wdt_stb = wdt_lvl & ~q.wdt_prev;

    // enabled channels in level mode with the pin low may wake us
    generate
        for (genvar g = 0; g < `NUM_CH; g++) begin : g_wake
            assign wake_low[g] = q.enable[`ENA_CH0_BIT + g] &&
                (sense_of(q.sense, g) == SENSE_LOW) && !pin_lvl[g];
        end
    endgenerate

    level_wake u_wake (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .sample_stb(wdt_stb),
        .low_req(wake_low),
        .power_down(power_down),
        .startup_done(startup_done),
        .wake(wake_pulse)
    );

    // next state of the whole unit
    always_comb begin
        logic [`NUM_CH-1:0] ev;
        logic [`NUM_CH-1:0] lvl_mode;
        logic [`NUM_CH-1:0] lvl_low;
        logic [`NUM_CH-1:0] clr;
        logic [`NUM_CH-1:0] pend;
        logic [`EVT_W-1:0] evt_set;
        logic [`EVT_W-1:0] evt_clr;
        logic [`DATA_W-1:0] flag_rd;
        sense_t mode;
        ev = '0;
        lvl_mode = '0;
        lvl_low = '0;
        clr = '0;
        pend = '0;
        evt_set = '0;
        evt_clr = '0;
        flag_rd = `RST_BYTE;
        mode = SENSE_LOW;
        d = q;

        // keep previous samples fresh even while the I/O clock is off
        d.pin_prev = pin_lvl;
        d.wdt_prev = wdt_lvl;

        for (int ch = 0; ch < `NUM_CH; ch++) begin
            mode = sense_of(q.sense, ch);
            lvl_mode[ch] = (mode == SENSE_LOW);
            // output direction of the pin is of no concern here
            ev[ch] = io_clk_run &&
                edge_hit(mode, pin_lvl[ch], q.pin_prev[ch]);
            lvl_low[ch] = lvl_mode[ch] && !pin_lvl[ch];
            clr[ch] = (irq_ack && (irq_ack_ch == ch[0])) ||
                (reg_wr && (reg_addr == `OFF_FLAGS) &&
                 reg_wdata[`FLAG_CH0_BIT + ch]);
        end

        // control registers
        if (reg_wr) begin
            case (reg_addr)
                `OFF_SENSE: d.sense = reg_wdata;
                `OFF_ENABLE: d.enable = reg_wdata & `ENA_RW_MASK;
                `OFF_EVT_MASK: d.evt_mask = reg_wdata[`EVT_W-1:0];
                default: d.enable = q.enable;
            endcase
        end

        // flags: a fresh event outlives a clear in the same cycle
        for (int ch = 0; ch < `NUM_CH; ch++) begin
            if (lvl_mode[ch]) begin
                d.flag[ch] = 1'b0;
            end else begin
                d.flag[ch] = ev[ch] | (q.flag[ch] & ~clr[ch]);
            end
            pend[ch] = q.enable[`ENA_CH0_BIT + ch] &&
                (q.flag[ch] || lvl_low[ch]);
        end

        // request lines to the processor need the global enable too
        d.req = global_irq_en ? pend : '0;

        // wake pulse handed straight out
        d.wake = wake_pulse;

        // sticky event status, cleared by reading it
        evt_set[`NUM_CH-1:0] = ev & ~lvl_mode;
        evt_set[`EVT_WAKE] = wake_pulse;
        if (reg_rd && (reg_addr == `OFF_EVT_STAT)) begin
            evt_clr = '1;
        end
        d.evt_stat = evt_set | (q.evt_stat & ~evt_clr);
        d.irq = |(d.evt_stat & d.evt_mask);

        // read data stand only in the cycle after the strobe
        for (int ch = 0; ch < `NUM_CH; ch++) begin
            flag_rd[`FLAG_CH0_BIT + ch] = q.flag[ch] & ~lvl_mode[ch];
        end
        d.rdata = `RST_BYTE;
        if (reg_rd) begin
            case (reg_addr)
                `OFF_SENSE: d.rdata = q.sense;
                `OFF_ENABLE: d.rdata = q.enable;
                `OFF_FLAGS: d.rdata = flag_rd;
                `OFF_EVT_STAT: d.rdata = {5'h00, q.evt_stat};
                `OFF_EVT_MASK: d.rdata = {5'h00, q.evt_mask};
                default: d.rdata = `RST_BYTE;
            endcase
        end
    end

    // clock enable freezes every bit, the read data included
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '{sense: `RST_BYTE, enable: `RST_BYTE, flag: '0,
                   evt_stat: '0, evt_mask: '0, pin_prev: '1,
                   wdt_prev: 1'b0, rdata: `RST_BYTE, req: '0,
                   wake: 1'b0, irq: 1'b0};
        end else if (clk_en) begin
            q <= d;
        end
    end

    // every output is a flip-flop
    assign reg_rdata = q.rdata;
    assign irq_req = q.req;
    assign wake_req = q.wake;
    assign event_irq = q.irq;

endmodule : external_pin_interrupt_unit

// >>> pin_source.sv
// Purpose: model of the sources that drive the two interrupt pins
// Assumes: the bench commands each pin level through want
// Notes: the watchdog oscillator free-runs, unrelated to ref_clk
`timescale 1ns/1ns

module pin_source (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // levels commanded by the bench
    input wire logic [1:0] want,
    // pins and oscillator
    output logic ext_irq_pin_0,
    output logic ext_irq_pin_1,
    output logic wdt_osc
);
    // a source holds its level until told otherwise, so slow waits work
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ext_irq_pin_0 <= 1'b1;
            ext_irq_pin_1 <= 1'b1;
        end else begin
            ext_irq_pin_0 <= want[0];
            ext_irq_pin_1 <= want[1];
        end
    end

    // odd half period keeps the sample edges drifting against ref_clk
    initial wdt_osc = 1'b0;
    always #37 wdt_osc = ~wdt_osc;
endmodule : pin_source

// >>> pin_irq_checker.sv
// Purpose: port-level checks of the pin interrupt unit
// Assumes: clk_en drops only around writes the shadows ignore
// Notes: bound to every instance of the unit
`timescale 1ns/1ns
`include "ext_irq_cfg.svh"

module pin_irq_checker import ext_irq_pkg::*; (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // register port
    input wire logic [`ADDR_W-1:0] reg_addr,
    input wire logic [`DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [`DATA_W-1:0] reg_rdata,
    // pins and processor side
    input wire logic ext_irq_pin_0,
    input wire logic ext_irq_pin_1,
    input wire logic global_irq_en,
    input wire logic irq_ack,
    input wire logic io_clk_run,
    input wire logic power_down,
    input wire logic [`NUM_CH-1:0] irq_req,
    input wire logic wake_req
);
    logic [3:0] sense_q;
    logic [1:0] ena_q;
    wire logic quiet = global_irq_en && io_clk_run && !irq_ack && !reg_wr;

    // shadow of the sense fields and channel enables
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sense_q <= 4'h0;
            ena_q <= 2'h0;
        end else if (reg_wr) begin
            if (reg_addr == `OFF_SENSE) sense_q <= reg_wdata[3:0];
            if (reg_addr == `OFF_ENABLE) ena_q <= reg_wdata[7:6];
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    // held edges and a held low level must show up well inside the window
    sequence fall0_s;
        $fell(ext_irq_pin_0) && sense_q[1:0] == 2'h2 && ena_q[0]
            ##1 (quiet && !ext_irq_pin_0) [*8];
    endsequence
    sequence rise1_s;
        $rose(ext_irq_pin_1) && sense_q[3:2] == 2'h3 && ena_q[1]
            ##1 (quiet && ext_irq_pin_1) [*8];
    endsequence
    sequence low0_s;
        (sense_q[1:0] == 2'h0 && ena_q[0] && global_irq_en && !power_down
            && !ext_irq_pin_0) [*8];
    endsequence

    fall_req_a: assert property (fall0_s |-> irq_req[0])
        else $error("falling edge gave no request");
    rise_req_a: assert property (rise1_s |-> irq_req[1])
        else $error("rising edge gave no request");
    level_req_a: assert property (low0_s |-> irq_req[0])
        else $error("held low level gave no request");
    level_flag_a: assert property ($past(reg_rd)
        && $past(reg_addr) == `OFF_FLAGS && sense_q[1:0] == 2'h0
        && $past(sense_q[1:0]) == 2'h0 |-> !reg_rdata[6])
        else $error("flag read set in level mode");
    ena_gate_a: assert property (
        (irq_req & ~(ena_q | $past(ena_q))) == 2'h0)
        else $error("request on a disabled channel");
    global_gate_a: assert property (irq_req != 2'h0
        |-> global_irq_en || $past(global_irq_en))
        else $error("request without global enable");
    wake_pulse_a: assert property (wake_req |=> !wake_req)
        else $error("wake longer than one cycle");
    wake_cause_a: assert property (wake_req |-> $past(power_down, 2))
        else $error("wake outside power-down");
endmodule : pin_irq_checker

bind external_pin_interrupt_unit pin_irq_checker chk (
    .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_irq_pin_0(ext_irq_pin_0),
    .ext_irq_pin_1(ext_irq_pin_1), .global_irq_en(global_irq_en),
    .irq_ack(irq_ack), .io_clk_run(io_clk_run), .power_down(power_down),
    .irq_req(irq_req), .wake_req(wake_req)
);

// >>> external_pin_interrupt_unit_tb.sv
// Purpose: register-level tests of the pin interrupt unit
// Assumes: clk_en high but for one frozen write; pins from source model
// Notes: fixed waits cover the synchroniser delay with margin
`timescale 1ns/1ns
`include "ext_irq_cfg.svh"

module external_pin_interrupt_unit_tb import ext_irq_pkg::*;;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic global_irq_en = 1'b0;
    logic irq_ack = 1'b0;
    logic irq_ack_ch = 1'b0;
    logic io_clk_run = 1'b1;
    logic power_down = 1'b0;
    logic startup_done = 1'b0;
    logic [1:0] want = 2'h3;
    logic [7:0] reg_rdata;
    logic [1:0] irq_req;
    logic pin0, pin1, wdt_osc, wake_req, event_irq;
    int n_errors = 0;
    int checks = 0;

    always #2 ref_clk = ~ref_clk;

    external_pin_interrupt_unit dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_irq_pin_0(pin0),
        .ext_irq_pin_1(pin1), .wdt_osc(wdt_osc),
        .global_irq_en(global_irq_en), .irq_ack(irq_ack),
        .irq_ack_ch(irq_ack_ch), .io_clk_run(io_clk_run),
        .power_down(power_down), .startup_done(startup_done),
        .irq_req(irq_req), .wake_req(wake_req), .event_irq(event_irq)
    );
    pin_source src (
        .ref_clk(ref_clk), .arst_n(arst_n), .want(want),
        .ext_irq_pin_0(pin0), .ext_irq_pin_1(pin1), .wdt_osc(wdt_osc)
    );

    task automatic results();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp

    task automatic cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t bit %b exp %b", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc

    // strobes change just after an edge and last one cycle
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // idle edge, so a following write never reassigns the strobe
        @(posedge ref_clk);
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        cmp(reg_rdata, exp);
        @(posedge ref_clk);
    endtask : rd

    // 0,1 request per channel, 2 wake, 3 summary; bounded, ends on an edge
    task automatic wait_bit(input int w, input logic v);
        logic [3:0] all;
        int n;
        n = 0;
        all = {event_irq, wake_req, irq_req};
        while (all[w] !== v && n < 400) begin
            @(negedge ref_clk);
            all = {event_irq, wake_req, irq_req};
            n++;
        end
        cmp_bit(all[w], v);
        if (all[w] !== v) results();
        @(posedge ref_clk);
    endtask : wait_bit

    initial begin
        cyc(4);
        arst_n <= 1'b1;
        rd(`OFF_SENSE, 8'h00);
        rd(`OFF_FLAGS, 8'h00);
        rd(3'h7, 8'h00);
        wr(`OFF_ENABLE, 8'hff);
        rd(`OFF_ENABLE, 8'hc3);
        wr(`OFF_SENSE, 8'hf0);
        rd(`OFF_SENSE, 8'hf0);
        global_irq_en <= 1'b1;
        // every edge mode on both channels, flag cleared by writing one
        for (int ch = 0; ch < 2; ch++) begin
            for (int m = 1; m < 4; m++) begin
                wr(`OFF_SENSE, 8'(m << (2 * ch)));
                wr(`OFF_FLAGS, 8'hc0);
                want[ch] <= 1'b0;
                cyc(12);
                rd(`OFF_FLAGS, (m != 3) ? 8'(8'h40 << ch) : 8'h00);
                wr(`OFF_FLAGS, 8'hc0);
                rd(`OFF_FLAGS, 8'h00);
                want[ch] <= 1'b1;
                cyc(12);
                rd(`OFF_FLAGS, (m != 2) ? 8'(8'h40 << ch) : 8'h00);
                cmp_bit(irq_req[ch], m != 2);
                cmp_bit(event_irq, 1'b0);
            end
        end
        // global gate, then vector entry clears the channel 1 flag
        global_irq_en <= 1'b0;
        cyc(3);
        cmp_bit(irq_req[1], 1'b0);
        global_irq_en <= 1'b1;
        irq_ack <= 1'b1;
        irq_ack_ch <= 1'b1;
        cyc(1);
        irq_ack <= 1'b0;
        cyc(3);
        rd(`OFF_FLAGS, 8'h00);
        // event status clears on read; mask lets the summary through
        rd(`OFF_EVT_STAT, 8'h03);
        rd(`OFF_EVT_STAT, 8'h00);
        wr(`OFF_EVT_MASK, 8'h01);
        wr(`OFF_SENSE, 8'h02);
        want[0] <= 1'b0;
        wait_bit(3, 1'b1);
        rd(`OFF_EVT_STAT, 8'h01);
        cyc(2);
        cmp_bit(event_irq, 1'b0);
        // a write while the clock enable is low must not land
        clk_en <= 1'b0;
        wr(`OFF_EVT_MASK, 8'h07);
        clk_en <= 1'b1;
        rd(`OFF_EVT_MASK, 8'h01);
        want[0] <= 1'b1;
        cyc(12);
        // edges while the io clock is stopped are lost
        wr(`OFF_FLAGS, 8'hc0);
        io_clk_run <= 1'b0;
        want[0] <= 1'b0;
        cyc(12);
        io_clk_run <= 1'b1;
        cyc(4);
        rd(`OFF_FLAGS, 8'h00);
        // any-change mode leaves a flag set for level mode to clear
        wr(`OFF_SENSE, 8'h01);
        want[0] <= 1'b1;
        cyc(12);
        // level mode: request while low, flag reads clear
        wr(`OFF_SENSE, 8'h00);
        cyc(2);
        cmp_bit(irq_req[0], 1'b0);
        want[0] <= 1'b0;
        wait_bit(0, 1'b1);
        rd(`OFF_FLAGS, 8'h00);
        cyc(20);
        cmp_bit(irq_req[0], 1'b1);
        want[0] <= 1'b1;
        wait_bit(0, 1'b0);
        // wake from power-down, level held, then level gone early
        for (int k = 0; k < 2; k++) begin
            power_down <= 1'b1;
            io_clk_run <= 1'b0;
            want[0] <= 1'b0;
            wait_bit(2, 1'b1);
            want[0] <= (k == 1);
            cyc(8);
            startup_done <= 1'b1;
            cyc(1);
            startup_done <= 1'b0;
            power_down <= 1'b0;
            io_clk_run <= 1'b1;
            cyc(12);
            cmp_bit(irq_req[0], k == 0);
            want[0] <= 1'b1;
            cyc(12);
        end
        rd(`OFF_EVT_STAT, 8'h05);
        results();
    end
endmodule : external_pin_interrupt_unit_tb
